/* File: logic/bbls_exec.sv */
// Purpose: Executes branches, bit operations, shifts and loads/stores of an 8-bit core slice.
// Assumes: Data memory read data is combinational on the held address; I/O space applies masked writes.
// Notes: Core state (registers, flags, PC) is also visible and, while stopped, writable over APB.
`default_nettype none

module bbls_exec
  import bbls_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction stream
  input wire logic instr_valid,
  input wire bbls_instr_type instr,
  output logic instr_ready,
  // Data memory
  output bbls_dmem_type dmem,
  input wire logic [7:0] dmem_rdata,
  // I/O space
  output bbls_io_type io
);

  typedef enum logic [0:0] {
    S_IDLE,
    S_BUSY
  } bbls_state_type;

  logic [7:0] gpr_q [32];
  logic [7:0] flags_q;
  logic [15:0] pc_q;
  logic [31:0] retired_q;
  logic run_q;
  bbls_state_type state_q;
  logic [1:0] cnt_q;
  logic ready_q;
  logic load_pend_q;
  logic [4:0] load_rd_q;
  bbls_dmem_type dmem_q;
  bbls_io_type io_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  logic accept;
  logic apb_setup;
  logic apb_wr;
  logic core_wr_ok;
  logic is_branch;
  logic cond;
  logic [7:0] rdv;
  logic [7:0] rrv;
  logic [7:0] sh_res;
  logic sh_c;
  logic [4:0] ptr_lo;
  logic [4:0] ptr_hi;
  logic [15:0] ptr_val;
  logic [15:0] ptr_new;
  logic [15:0] eff_addr;
  logic [15:0] pc_next;
  logic [15:0] pc_target;
  logic [1:0] cycles;
  logic [7:0] bmask;

  assign accept = instr_valid && ready_q;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready_q && pwrite;
  // Core state is only writable over APB while stopped and idle, so software never races an instruction
  assign core_wr_ok = apb_wr && !run_q && state_q == S_IDLE;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign instr_ready = ready_q;
  assign dmem = dmem_q;
  assign io = io_q;

  // Branch condition
  always_comb begin
    is_branch = 1'b1;
    cond = 1'b0;
    case (instr.op)
      OP_BRANCH_SIGNED_GE: cond = (flags_q[FLAG_N] ^ flags_q[FLAG_V]) == 1'b0; // RULE1
      OP_BRANCH_SIGNED_LT: cond = (flags_q[FLAG_N] ^ flags_q[FLAG_V]) == 1'b1; // RULE2
      OP_BRANCH_HALFCARRY_SET: cond = flags_q[FLAG_H]; // RULE3
      OP_BRANCH_HALFCARRY_CLEAR: cond = !flags_q[FLAG_H]; // RULE3
      OP_BRANCH_TBIT_SET: cond = flags_q[FLAG_T]; // RULE4
      OP_BRANCH_TBIT_CLEAR: cond = !flags_q[FLAG_T]; // RULE4
      OP_BRANCH_OVERFLOW_SET: cond = flags_q[FLAG_V]; // RULE5
      OP_BRANCH_OVERFLOW_CLEAR: cond = !flags_q[FLAG_V]; // RULE5
      OP_BRANCH_IRQ_ENABLED: cond = flags_q[FLAG_I]; // RULE6
      OP_BRANCH_IRQ_DISABLED: cond = !flags_q[FLAG_I]; // RULE6
      default: is_branch = 1'b0;
    endcase
  end

  // Shift and rotate data path
  always_comb begin
    rdv = gpr_q[instr.rd];
    rrv = gpr_q[instr.rr];
    sh_res = rdv;
    sh_c = flags_q[FLAG_C];
    case (instr.op)
      OP_SHIFT_LEFT_LOGICAL: begin
        sh_res = {rdv[6:0], 1'b0}; // RULE20
        sh_c = rdv[7];
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        sh_res = {1'b0, rdv[7:1]}; // RULE20
        sh_c = rdv[0];
      end
      OP_ROTATE_LEFT_CARRY: begin
        sh_res = {rdv[6:0], flags_q[FLAG_C]}; // RULE8
        sh_c = rdv[7];
      end
      OP_ROTATE_RIGHT_CARRY: begin
        sh_res = {flags_q[FLAG_C], rdv[7:1]}; // RULE8
        sh_c = rdv[0];
      end
      OP_SHIFT_RIGHT_ARITH: begin
        sh_res = {rdv[7], rdv[7:1]}; // RULE20
        sh_c = rdv[0];
      end
      default: begin
        sh_res = rdv;
        sh_c = flags_q[FLAG_C];
      end
    endcase
  end

  // Address generation
  always_comb begin
    case (instr.ptr)
      PTR_X: ptr_lo = PTR_X_LO;
      PTR_Y: ptr_lo = PTR_Y_LO;
      default: ptr_lo = PTR_Z_LO;
    endcase
    ptr_hi = ptr_lo | 5'h01;
    ptr_val = {gpr_q[ptr_hi], gpr_q[ptr_lo]};
    ptr_new = ptr_val;
    eff_addr = ptr_val;
    case (instr.op)
      OP_LOAD_INDIRECT, OP_STORE_INDIRECT: begin
        if (instr.amode == AM_POST_INC) begin
          ptr_new = ptr_val + 16'h0001; // RULE12 RULE16
        end else if (instr.amode == AM_PRE_DEC) begin
          ptr_new = ptr_val - 16'h0001; // RULE13 RULE17
          eff_addr = ptr_new; // RULE13 RULE17
        end
      end
      OP_LOAD_DISPLACED, OP_STORE_DISPLACED: eff_addr = ptr_val + {10'h000, instr.disp}; // RULE14 RULE18
      OP_LOAD_DIRECT, OP_STORE_DIRECT: eff_addr = instr.addr; // RULE15
      default: eff_addr = ptr_val;
    endcase
  end

  // Program counter and cycle count
  always_comb begin
    pc_next = pc_q + 16'h0001;
    pc_target = pc_q + {{9{instr.offset[6]}}, instr.offset} + 16'h0001;
    bmask = 8'h01 << instr.bsel;
    cycles = 2'h1;
    case (instr.op)
      OP_IO_BIT_SET, OP_IO_BIT_CLEAR: cycles = CYC_IO; // RULE7
      OP_LOAD_INDIRECT, OP_STORE_INDIRECT, OP_LOAD_DISPLACED, OP_STORE_DISPLACED,
      OP_LOAD_DIRECT, OP_STORE_DIRECT: cycles = CYC_MEM;
      default: cycles = (is_branch && cond) ? CYC_BRANCH_TAKEN : 2'h1;
    endcase
  end

  // Sequencing: ready, busy count, retired count
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      cnt_q <= 2'h0;
      ready_q <= 1'b0;
      retired_q <= 32'h0000_0000;
    end else begin
      if (accept) begin
        retired_q <= retired_q + 32'h0000_0001;
      end
      case (state_q)
        S_IDLE: begin
          if (accept && cycles > 2'h1) begin
            state_q <= S_BUSY;
            cnt_q <= cycles - 2'h2;
            ready_q <= 1'b0;
          end else begin
            ready_q <= run_q;
          end
        end
        S_BUSY: begin
          // Ready returns only when the second cycle ends, so nothing is taken mid-access
          if (cnt_q == 2'h0) begin
            state_q <= S_IDLE;
            ready_q <= run_q;
          end else begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
        default: begin
          state_q <= S_IDLE;
          ready_q <= 1'b0;
        end
      endcase
    end
  end

  // Program counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_q <= PC_RST;
    end else if (accept) begin
      if (is_branch && cond) begin
        pc_q <= pc_target; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6
      end else begin
        pc_q <= pc_next; // RULE22
      end
    end else if (core_wr_ok && paddr == REG_PC) begin
      pc_q <= pwdata[15:0];
    end
  end

  // Status flags; branches, moves, loads and stores leave them alone
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_q <= FLAGS_RST;
    end else if (accept) begin
      case (instr.op)
        OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH: begin
          flags_q[FLAG_C] <= sh_c; // RULE8
          flags_q[FLAG_Z] <= sh_res == 8'h00; // RULE8
          flags_q[FLAG_N] <= sh_res[7]; // RULE8
          flags_q[FLAG_V] <= sh_res[7] ^ sh_c; // RULE8
        end
        OP_FLAG_SET_GENERIC: flags_q[instr.bsel] <= 1'b1; // RULE11 RULE19
        OP_FLAG_CLEAR_GENERIC: flags_q[instr.bsel] <= 1'b0; // RULE11 RULE19
        OP_BIT_TO_TRANSFER: flags_q[FLAG_T] <= rrv[instr.bsel]; // RULE9
        default: flags_q <= flags_q;
      endcase
    end else if (core_wr_ok && paddr == REG_FLAGS) begin
      flags_q <= pwdata[7:0];
    end
  end

  // Register file
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) begin
        gpr_q[i] <= GPR_RST;
      end
    end else if (accept) begin
      case (instr.op)
        OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH: gpr_q[instr.rd] <= sh_res; // RULE8 RULE20
        OP_SWAP_NIBBLES: gpr_q[instr.rd] <= {rdv[3:0], rdv[7:4]}; // RULE20
        OP_TRANSFER_TO_BIT: gpr_q[instr.rd] <= (rdv & ~bmask) | (flags_q[FLAG_T] ? bmask : 8'h00); // RULE10
        OP_MOVE_REG: gpr_q[instr.rd] <= rrv; // RULE21
        OP_COPY_REGISTER_PAIR: begin
          gpr_q[{instr.rd[4:1], 1'b0}] <= gpr_q[{instr.rr[4:1], 1'b0}]; // RULE21
          gpr_q[{instr.rd[4:1], 1'b1}] <= gpr_q[{instr.rr[4:1], 1'b1}]; // RULE21
        end
        OP_LOAD_CONSTANT: gpr_q[instr.rd] <= instr.imm; // RULE21
        OP_LOAD_INDIRECT, OP_STORE_INDIRECT: begin
          // Pointer written back at issue; the address already holds the old or pre-decremented value
          gpr_q[ptr_lo] <= ptr_new[7:0]; // RULE12 RULE13 RULE16 RULE17
          gpr_q[ptr_hi] <= ptr_new[15:8]; // RULE12 RULE13 RULE16 RULE17
        end
        default: gpr_q[instr.rd] <= gpr_q[instr.rd];
      endcase
    end else if (state_q == S_BUSY && load_pend_q) begin
      // Loaded byte lands last, so it wins over a pointer update of the same register
      gpr_q[load_rd_q] <= dmem_rdata; // RULE12 RULE13 RULE14 RULE15
    end else if (core_wr_ok && paddr[11:7] == REG_GPR_PAGE && paddr[1:0] == 2'h0) begin
      gpr_q[paddr[6:2]] <= pwdata[7:0];
    end
  end

  // Data memory request, held for the whole second cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dmem_q <= '0;
      load_pend_q <= 1'b0;
      load_rd_q <= 5'h00;
    end else if (accept) begin
      dmem_q.addr <= eff_addr;
      dmem_q.wdata <= rrv;
      load_rd_q <= instr.rd;
      case (instr.op)
        OP_LOAD_INDIRECT, OP_LOAD_DISPLACED, OP_LOAD_DIRECT: begin
          dmem_q.req <= 1'b1; // RULE12 RULE13 RULE14 RULE15
          dmem_q.we <= 1'b0;
          load_pend_q <= 1'b1;
        end
        OP_STORE_INDIRECT, OP_STORE_DISPLACED, OP_STORE_DIRECT: begin
          dmem_q.req <= 1'b1; // RULE16 RULE17 RULE18
          dmem_q.we <= 1'b1;
          load_pend_q <= 1'b0;
        end
        default: begin
          dmem_q.req <= 1'b0;
          dmem_q.we <= 1'b0;
          load_pend_q <= 1'b0;
        end
      endcase
    end else if (state_q == S_BUSY && cnt_q == 2'h0) begin
      dmem_q.req <= 1'b0;
      dmem_q.we <= 1'b0;
      load_pend_q <= 1'b0;
    end
  end

  // I/O bit write as one masked write; avoids a read-modify-write racing the next instruction
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_q <= '0;
    end else if (accept && (instr.op == OP_IO_BIT_SET || instr.op == OP_IO_BIT_CLEAR)) begin
      io_q.we <= 1'b1; // RULE7
      io_q.addr <= instr.io_addr;
      io_q.wmask <= bmask; // RULE7
      io_q.wdata <= instr.op == OP_IO_BIT_SET ? bmask : 8'h00; // RULE7
    end else begin
      io_q.we <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_q <= CTRL_RUN_RST;
    end else if (apb_wr && paddr == REG_CTRL) begin
      run_q <= pwdata[CTRL_RUN];
    end
  end

  // APB answer: no wait state, read data captured in the setup cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (apb_setup) begin
      pready_q <= 1'b1;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      if (paddr == REG_CTRL) begin
        prdata_q <= {31'h0000_0000, run_q};
      end else if (paddr == REG_FLAGS) begin
        prdata_q <= {24'h00_0000, flags_q};
      end else if (paddr == REG_PC) begin
        prdata_q <= {16'h0000, pc_q};
      end else if (paddr == REG_RETIRED) begin
        prdata_q <= retired_q;
      end else if (paddr[11:7] == REG_GPR_PAGE && paddr[1:0] == 2'h0) begin
        prdata_q <= {24'h00_0000, gpr_q[paddr[6:2]]};
      end else begin
        pslverr_q <= 1'b1;
      end
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: logic/bbls_pkg.sv */
// Purpose: Shared constants, encodings and carriers of the branch, bit and load/store execution slice.
// Assumes: 8-bit data path, 16-bit program counter and data addresses, single 100 MHz core clock.
// Notes: Registers are reached over APB with 32-bit aligned words; narrow values sit in the low bits.
// Overview of operation
// RULE1: Signed >= branch taken when N xor V zero
// RULE2: Signed < branch taken when N xor V one
// RULE3: Half-carry branches test H set or clear
// RULE4: Transfer-bit branches test T set or clear
// RULE5: Overflow branches test V set or clear
// RULE6: Interrupt-state branches test I set or clear
// RULE7: I/O bit set/clear, two cycles, flags kept
// RULE8: Rotates through carry, one cycle, Z C N V
// RULE9: Register bit copied into T only
// RULE10: T copied into register bit, flags kept
// RULE11: Flag instructions set or clear one flag
// RULE12: Post-increment load reads then bumps pointer
// RULE13: Pre-decrement load drops pointer then reads
// RULE14: Displacement load leaves pointer, two cycles
// RULE15: Direct load from encoded address, two cycles
// RULE16: Post-increment store writes then bumps pointer
// RULE17: Pre-decrement store drops pointer then writes
// RULE18: Displacement store leaves pointer, two cycles
// RULE19: Sign flag set or clear, others kept
// RULE20: Shifts zero-fill, arithmetic keeps bit 7, swap nibbles
// RULE21: Move, pair copy, constant load: one cycle
// RULE22: Untaken branch goes to next, flags kept
`default_nettype none

package bbls_pkg;

  // Status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Low byte of each pointer pair in the register file
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;

  // APB byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_FLAGS = 12'h004;
  localparam logic [11:0] REG_PC = 12'h008;
  localparam logic [11:0] REG_RETIRED = 12'h00c;
  localparam logic [4:0] REG_GPR_PAGE = 5'h02;
  localparam int CTRL_RUN = 0;

  // Values after reset
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] GPR_RST = 8'h00;

  // Cycles per instruction class
  localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
  localparam logic [1:0] CYC_MEM = 2'h2;
  localparam logic [1:0] CYC_IO = 2'h2;

  typedef enum logic [5:0] {
    OP_NOP,
    OP_BRANCH_SIGNED_GE,
    OP_BRANCH_SIGNED_LT,
    OP_BRANCH_HALFCARRY_SET,
    OP_BRANCH_HALFCARRY_CLEAR,
    OP_BRANCH_TBIT_SET,
    OP_BRANCH_TBIT_CLEAR,
    OP_BRANCH_OVERFLOW_SET,
    OP_BRANCH_OVERFLOW_CLEAR,
    OP_BRANCH_IRQ_ENABLED,
    OP_BRANCH_IRQ_DISABLED,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_SHIFT_LEFT_LOGICAL,
    OP_SHIFT_RIGHT_LOGICAL,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_SHIFT_RIGHT_ARITH,
    OP_SWAP_NIBBLES,
    OP_FLAG_SET_GENERIC,
    OP_FLAG_CLEAR_GENERIC,
    OP_BIT_TO_TRANSFER,
    OP_TRANSFER_TO_BIT,
    OP_MOVE_REG,
    OP_COPY_REGISTER_PAIR,
    OP_LOAD_CONSTANT,
    OP_LOAD_INDIRECT,
    OP_STORE_INDIRECT,
    OP_LOAD_DISPLACED,
    OP_STORE_DISPLACED,
    OP_LOAD_DIRECT,
    OP_STORE_DIRECT
  } bbls_op_type;

  typedef enum logic [1:0] {
    PTR_X,
    PTR_Y,
    PTR_Z
  } bbls_ptr_type;

  typedef enum logic [1:0] {
    AM_PLAIN,
    AM_POST_INC,
    AM_PRE_DEC
  } bbls_amode_type;

  typedef struct packed {
    bbls_op_type op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bsel;
    logic [7:0] imm;
    logic [6:0] offset;
    logic [5:0] disp;
    logic [15:0] addr;
    logic [5:0] io_addr;
    bbls_ptr_type ptr;
    bbls_amode_type amode;
  } bbls_instr_type;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bbls_dmem_type;

  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
  } bbls_io_type;

endpackage

`default_nettype wire

/* File: tb/bbls_exec_monitor.sv */
// Purpose: Port-level checker for bbls_exec.
// Assumes: One clock; sys_rst synchronous, active high.
// Notes: Bound to every instance of bbls_exec.
`default_nettype none

module bbls_exec_monitor
  import bbls_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Instruction stream
  input wire logic instr_valid,
  input wire bbls_instr_type instr,
  input wire logic instr_ready,
  // Memory and I/O
  input wire bbls_dmem_type dmem,
  input wire logic [7:0] dmem_rdata,
  input wire bbls_io_type io
);
  timeunit 1ns;
  timeprecision 1ps;
  logic acc, mem_op, st_op, io_op, one_op;

  assign acc = instr_valid && instr_ready;
  assign st_op = instr.op inside {OP_STORE_INDIRECT, OP_STORE_DISPLACED, OP_STORE_DIRECT};
  assign mem_op = st_op || (instr.op inside {OP_LOAD_INDIRECT, OP_LOAD_DISPLACED, OP_LOAD_DIRECT});
  assign io_op = instr.op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR};
  assign one_op = instr.op inside {[OP_SHIFT_LEFT_LOGICAL:OP_LOAD_CONSTANT]};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_apb_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_apb_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_mem_two_cycle: assert property (acc && mem_op |=> dmem.req && !instr_ready ##1 instr_ready && !dmem.req)
    else $error("memory access timing wrong");
  a_mem_direction: assert property (acc && mem_op |=> dmem.we == $past(st_op))
    else $error("memory direction wrong");
  a_direct_addr: assert property (acc && instr.op inside {OP_LOAD_DIRECT, OP_STORE_DIRECT} |=> dmem.addr == $past(instr.addr))
    else $error("direct address wrong");
  a_dmem_cause: assert property (dmem.req |-> $past(acc && mem_op))
    else $error("memory request without instruction");
  a_io_mask: assert property (acc && io_op |=> io.we && io.wmask == (8'h01 << $past(instr.bsel)) && io.addr == $past(instr.io_addr) && !instr_ready ##1 !io.we && instr_ready)
    else $error("io bit write wrong");
  a_io_level: assert property (io.we |-> io.wdata == (($past(instr.op) == OP_IO_BIT_SET) ? io.wmask : 8'h00))
    else $error("io bit level wrong");
  a_single_cycle: assert property (acc && one_op |=> instr_ready && !dmem.req && !io.we)
    else $error("single cycle op stalled");

  c_mem: cover property (acc && mem_op);
  c_io: cover property (acc && io_op);
  c_err: cover property (pslverr);
endmodule

bind bbls_exec bbls_exec_monitor mon (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .dmem(dmem),
  .dmem_rdata(dmem_rdata), .io(io));

`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for bbls_exec.
// Assumes: Memory answers with the low address byte xor 8'h5a.
// Notes: Scenarios share one flag model, so their order matters.
`default_nettype none

module testbench
  import bbls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, instr_valid = 0;
  logic pready, pslverr, instr_ready, rdy1, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] dmem_rdata, fl = 8'h00;
  bbls_instr_type instr = '0;
  bbls_dmem_type dmem, dm;
  bbls_io_type io, iow;
  int num_errors = 0, n_tests = 0, cyc = 0;
  int fb[10] = '{FLAG_N, FLAG_N, FLAG_H, FLAG_H, FLAG_T, FLAG_T, FLAG_V, FLAG_V, FLAG_I, FLAG_I};
  `define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR %0t: got %h want %h", $time, a, e); end end

  always #5 clk = ~clk;
  assign dmem_rdata = dmem.addr[7:0] ^ 8'h5a;

  bbls_exec dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .dmem(dmem),
    .dmem_rdata(dmem_rdata), .io(io));

  task automatic close_out();
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Whole run needs under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d = 32'h0);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic cg(input logic [4:0] n, input logic [7:0] e);
    apb(0, 12'h100 + {5'h0, n, 2'h0});
    `CHK(rd, {24'h0, e})
  endtask

  task automatic cf();
    apb(0, REG_FLAGS);
    `CHK(rd, {24'h0, fl})
  endtask

  // Samples outputs in the cycle after acceptance, where dmem and io stand
  task automatic go(input bbls_instr_type i);
    @(posedge clk);
    instr <= i;
    instr_valid <= 1;
    do @(posedge clk); while (instr_ready !== 1'b1);
    instr_valid <= 0;
    @(negedge clk);
    rdy1 = instr_ready;
    dm = dmem;
    iow = io;
  endtask

  task automatic op(input bbls_op_type o, input logic [4:0] d, input logic [4:0] r = 5'h0,
      input logic [2:0] b = 3'h0, input logic [7:0] k = 8'h00);
    bbls_instr_type i;
    i = '0;
    i.op = o;
    i.rd = d;
    i.rr = r;
    i.bsel = b;
    i.imm = k;
    go(i);
  endtask

  task automatic fs(input int f, input logic s);
    op(s ? OP_FLAG_SET_GENERIC : OP_FLAG_CLEAR_GENERIC, 5'h0, 5'h0, 3'(f));
    fl[f] = s;
  endtask

  task automatic mem(input bbls_op_type o, input bbls_ptr_type p, input bbls_amode_type m,
      input logic [4:0] r, input logic [15:0] ea);
    bbls_instr_type i;
    i = '0;
    i.op = o;
    i.rd = r;
    i.rr = r;
    i.ptr = p;
    i.amode = m;
    i.disp = 6'h3f;
    i.addr = 16'h1234;
    go(i);
    `CHK({rdy1, dm.req, dm.addr}, {2'b01, ea})
  endtask

  task automatic t_reset();
    apb(0, REG_CTRL);
    `CHK(rd, 32'h1)
    apb(0, REG_PC);
    `CHK(rd, 32'h0)
    cf();
    apb(1, REG_RETIRED, 32'hff);
    apb(0, REG_RETIRED);
    `CHK(rd, 32'h0)
    apb(0, 12'h0f0);
    `CHK({err, rd}, 33'h100000000)
  endtask

  task automatic t_flags();
    for (int f = 0; f < 8; f++) begin
      fs(f, 1);
      `CHK(rdy1, 1'b1)
      cf();
      fs(f, 0);
      cf();
    end
  endtask

  task automatic t_branch();
    bbls_instr_type i;
    logic [15:0] p0, pe;
    logic pol, tk;
    for (int j = 0; j < 10; j++)
      for (int s = 0; s < 2; s++) begin
        pol = (j < 2) ? j[0] : !j[0];
        fs(fb[j], s[0]);
        apb(0, REG_PC);
        p0 = rd[15:0];
        i = '0;
        i.op = bbls_op_type'(6'(j + 1));
        i.offset = s ? 7'h7d : 7'h05;
        go(i);
        tk = (s[0] == pol);
        pe = tk ? p0 + {{9{i.offset[6]}}, i.offset} + 16'h1 : p0 + 16'h1;
        `CHK(rdy1, !tk)
        apb(0, REG_PC);
        `CHK(rd, {16'h0, pe})
        cf();
      end
  endtask

  task automatic t_mem();
    op(OP_LOAD_CONSTANT, 5'h1a, 5'h0, 3'h0, 8'hff);
    op(OP_LOAD_CONSTANT, 5'h1b, 5'h0, 3'h0, 8'h01);
    mem(OP_LOAD_INDIRECT, PTR_X, AM_POST_INC, 5'h01, 16'h01ff);
    cg(5'h01, 8'ha5);
    cg(5'h1a, 8'h00);
    cg(5'h1b, 8'h02);
    mem(OP_LOAD_INDIRECT, PTR_X, AM_PRE_DEC, 5'h02, 16'h01ff);
    cg(5'h02, 8'ha5);
    cg(5'h1b, 8'h01);
    op(OP_LOAD_CONSTANT, 5'h1c, 5'h0, 3'h0, 8'h10);
    mem(OP_LOAD_DISPLACED, PTR_Y, AM_PLAIN, 5'h03, 16'h004f);
    cg(5'h03, 8'h15);
    cg(5'h1c, 8'h10);
    mem(OP_LOAD_DIRECT, PTR_X, AM_PLAIN, 5'h04, 16'h1234);
    cg(5'h04, 8'h6e);
    mem(OP_STORE_INDIRECT, PTR_Z, AM_PRE_DEC, 5'h01, 16'hffff);
    `CHK({dm.we, dm.wdata}, 9'h1a5)
    cg(5'h1f, 8'hff);
    mem(OP_STORE_INDIRECT, PTR_Z, AM_POST_INC, 5'h02, 16'hffff);
    `CHK({dm.we, dm.wdata}, 9'h1a5)
    cg(5'h1e, 8'h00);
    mem(OP_STORE_DISPLACED, PTR_Z, AM_PLAIN, 5'h03, 16'h003f);
    `CHK({dm.we, dm.wdata}, 9'h115)
    cg(5'h1f, 8'h00);
    cf();
  endtask

  task automatic t_alu();
    logic [7:0] v, r;
    logic c;
    for (int j = 13; j < 19; j++)
      for (int s = 0; s < 2; s++) begin
        v = s ? 8'h01 : 8'h81;
        c = s[0];
        fs(FLAG_C, c);
        op(OP_LOAD_CONSTANT, 5'h05, 5'h0, 3'h0, v);
        op(bbls_op_type'(6'(j)), 5'h05);
        case (j)
          13: {c, r} = {v, 1'b0};
          14: {r, c} = {1'b0, v};
          15: {c, r} = {v, c};
          16: {r, c} = {c, v};
          17: {r, c} = {v[7], v};
          default: r = {v[3:0], v[7:4]};
        endcase
        // Shifts own V N Z C only; swap leaves every flag alone
        if (j != 18) fl[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
        `CHK(rdy1, 1'b1)
        cg(5'h05, r);
        cf();
      end
    fs(FLAG_T, 0);
    op(OP_LOAD_CONSTANT, 5'h06, 5'h0, 3'h0, 8'h20);
    op(OP_BIT_TO_TRANSFER, 5'h0, 5'h06, 3'h5);
    fl[FLAG_T] = 1;
    cf();
    op(OP_LOAD_CONSTANT, 5'h07, 5'h0, 3'h0, 8'h00);
    op(OP_TRANSFER_TO_BIT, 5'h07, 5'h0, 3'h2);
    cg(5'h07, 8'h04);
    op(OP_MOVE_REG, 5'h08, 5'h06);
    cg(5'h08, 8'h20);
    op(OP_COPY_REGISTER_PAIR, 5'h0a, 5'h07);
    `CHK(rdy1, 1'b1)
    cg(5'h0a, 8'h20);
    cg(5'h0b, 8'h04);
    cf();
  endtask

  task automatic t_io();
    bbls_instr_type i;
    i = '0;
    i.op = OP_IO_BIT_SET;
    i.io_addr = 6'h3f;
    i.bsel = 3'h7;
    go(i);
    `CHK({rdy1, iow}, {2'b01, 6'h3f, 8'h80, 8'h80})
    i.op = OP_IO_BIT_CLEAR;
    i.io_addr = 6'h00;
    i.bsel = 3'h0;
    go(i);
    `CHK({rdy1, iow}, {2'b01, 6'h00, 8'h00, 8'h01})
    cf();
  endtask

  // Reset in mid-run must bring back every value after reset
  task automatic t_midreset();
    @(posedge clk);
    sys_rst <= 1;
    repeat (3) @(posedge clk);
    sys_rst <= 0;
    fl = 8'h00;
    t_reset();
    cg(5'h05, 8'h00);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 0;
    t_reset();
    t_flags();
    t_branch();
    t_mem();
    t_alu();
    t_io();
    t_midreset();
    close_out();
  end
endmodule

`default_nettype wire
